// file: inc/scp_pkg.sv
// Package for the system clock and power mode controller
`default_nettype none
package scp_pkg;
    // Oscillator nominal rates
    localparam int FAST_RC_HZ = 8000000;
    localparam int SLOW_RC_HZ = 32000;
    localparam int CLK_HZ = 125000000;
    // Main-clock cycles per oscillator cycle, rounded down, at least one
    localparam int FAST_DIV_RAW = CLK_HZ / FAST_RC_HZ;
    localparam int FAST_DIV = (FAST_DIV_RAW < 1) ? 1 : FAST_DIV_RAW;
    localparam int SLOW_DIV_RAW = CLK_HZ / SLOW_RC_HZ;
    localparam int SLOW_DIV = (SLOW_DIV_RAW < 1) ? 1 : SLOW_DIV_RAW;
    // Oscillator start-up, in oscillator cycles
    localparam int FAST_SETTLE = 16;
    localparam int SLOW_SETTLE = 2;

    // Register offsets
    localparam logic [1:0] ADDR_MODE = 2'h0;
    localparam logic [1:0] ADDR_MODE_EXT = 2'h1;
    localparam logic [1:0] ADDR_STATUS = 2'h2;

    // Mode register fields
    localparam int F_DIV_HI = 7;
    localparam int F_DIV_LO = 5;
    localparam int F_SLOW_RDY = 3;
    localparam int F_FAST_RDY = 2;
    localparam int F_IDLE_EN = 1;
    localparam int F_HL_SEL = 0;
    localparam int F_SYS_IDLE = 7;
    localparam logic [7:0] MODE_RESET = 8'h03;
    localparam logic [7:0] MODE_EXT_RESET = 8'h00;

    // Divider codes
    localparam logic [2:0] DIV_SLOW_A = 3'h0;
    localparam logic [2:0] DIV_SLOW_B = 3'h1;
    localparam logic [5:0] PRE_ONES = 6'h3F;
    localparam logic [2:0] DIV_BASE = 3'h2;

    typedef enum logic [2:0] {
        MODE_NORMAL,
        MODE_SLOW,
        MODE_DEEP_SLEEP,
        MODE_SLEEP_WDT,
        MODE_IDLE_OFF,
        MODE_IDLE_ON
    } scp_mode_t;

    // Clock enables handed to the rest of the chip
    typedef struct packed {
        logic cpu_en;
        logic sys_en;
        logic slow_en;
        logic timebase_en;
        logic fast_on;
    } scp_clk_t;
endpackage : scp_pkg
`default_nettype wire

// file: logic/scp_osc.sv
// RC-oscillator model: enable-gated tick generator with ready flag
`default_nettype none
module scp_osc #(
    parameter int DIV = 2,
    parameter int SETTLE = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Control
    input wire logic run,
    // Outputs
    output logic tick,
    output logic ready
);
    logic [15:0] cnt_q;
    logic [7:0] settle_q;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= 16'h0000;
            tick <= 1'b0;
        end
        else if (!run)
        begin
            cnt_q <= 16'h0000;
            tick <= 1'b0;
        end
        else if (cnt_q == 16'(DIV - 1))
        begin
            cnt_q <= 16'h0000;
            tick <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 16'h0001;
            tick <= 1'b0;
        end
    end

    // Ready only after a number of stable cycles since start
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            settle_q <= 8'h00;
            ready <= 1'b0;
        end
        else if (!run)
        begin
            settle_q <= 8'h00;
            ready <= 1'b0;
        end
        else if (tick && settle_q != 8'(SETTLE))
            settle_q <= settle_q + 8'h01;
        else if (settle_q == 8'(SETTLE))
            ready <= 1'b1;
    end
endmodule // scp_osc
`default_nettype wire

// file: logic/scp_ctrl.sv
// System clock selection and power mode controller
// Functional notes
// - Two internal sources: fast RC near 8MHz, slow RC near 32kHz.
// - Slow oscillator also clocks watchdog and time-base interrupts.
// - System clock picked by high/low select and three-bit divider field.
// - Normal mode runs fast clock divided by 1 up to 64.
// - Time-base clock comes from slow oscillator, feeds time-base and timers.
// - Moving from fast to slow clock stops the fast oscillator.
// - Six modes: normal, slow running; four halted modes stop the CPU.
// - Slow mode: CPU on slow clock, fast clock off, slow and time-base on.
// - Halt, idle off, watchdog off: deep sleep, all clocks stopped.
// - Halt, idle off, watchdog on: sleep keeps slow clock only.
// - Halt, idle on, sysclk-in-idle off: system clock off, slow and time-base on.
// - Halt, idle on, sysclk-in-idle on: CPU off, system clock stays for peripherals.
// - Select low: codes 0,1 slow; 2..7 give fast over 64 down to 2.
// - Select high: undivided fast clock, divider field ignored.
`default_nettype none
module scp_ctrl (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Core events
    input wire logic halt_req,
    input wire logic wake_req,
    input wire logic watchdog_on,
    // Clock enables and power mode
    output scp_pkg::scp_clk_t clk_out,
    output scp_pkg::scp_mode_t mode_q
);
    logic rst_meta_q;
    logic rst_sync_n;
    logic [7:0] mode_reg_q;
    logic sys_idle_q;
    logic halted_q;
    logic use_slow_q;
    logic [2:0] cur_div_q;
    logic cur_hl_q;
    logic [5:0] pre_q;
    logic fast_run;
    logic slow_run;
    logic fast_tick;
    logic slow_tick;
    logic fast_rdy;
    logic slow_rdy;
    logic want_slow;
    logic sys_tick;
    logic [5:0] pre_need;
    scp_pkg::scp_mode_t mode_d;

    // Slow source wanted by the requested selection
    function automatic logic sel_slow(input logic hl, input logic [2:0] div);
        sel_slow = !hl && (div == scp_pkg::DIV_SLOW_A || div == scp_pkg::DIV_SLOW_B);
    endfunction

    // Reset release through two flops
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_n <= rst_meta_q;
        end
    end

    assign want_slow = sel_slow(mode_reg_q[scp_pkg::F_HL_SEL],
        mode_reg_q[scp_pkg::F_DIV_HI:scp_pkg::F_DIV_LO]);

    // fast off on slow
    // Fast oscillator stays until the switch to slow is done
    assign fast_run = !(use_slow_q && want_slow)
        && !(halted_q && mode_q != scp_pkg::MODE_IDLE_ON);
    assign slow_run = (mode_q != scp_pkg::MODE_DEEP_SLEEP);

    scp_osc #(.DIV(scp_pkg::FAST_DIV), .SETTLE(scp_pkg::FAST_SETTLE)) u_fast (
        .clock(clock),
        .rst_n(rst_sync_n),
        .run(fast_run),
        .tick(fast_tick),
        .ready(fast_rdy)
    );

    scp_osc #(.DIV(scp_pkg::SLOW_DIV), .SETTLE(scp_pkg::SLOW_SETTLE)) u_slow (
        .clock(clock),
        .rst_n(rst_sync_n),
        .run(slow_run),
        .tick(slow_tick),
        .ready(slow_rdy)
    );

    // Control registers
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            mode_reg_q <= scp_pkg::MODE_RESET;
            sys_idle_q <= 1'b0;
        end
        else if (reg_wr && reg_addr == scp_pkg::ADDR_MODE)
        begin
            // Ready flags are read-only, bit 4 unused
            mode_reg_q[scp_pkg::F_DIV_HI:scp_pkg::F_DIV_LO] <=
                reg_wdata[scp_pkg::F_DIV_HI:scp_pkg::F_DIV_LO];
            mode_reg_q[scp_pkg::F_IDLE_EN] <= reg_wdata[scp_pkg::F_IDLE_EN];
            mode_reg_q[scp_pkg::F_HL_SEL] <= reg_wdata[scp_pkg::F_HL_SEL];
        end
        else if (reg_wr && reg_addr == scp_pkg::ADDR_MODE_EXT)
            sys_idle_q <= reg_wdata[scp_pkg::F_SYS_IDLE];
    end

    // Read data one cycle after the strobe
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                scp_pkg::ADDR_MODE:
                begin
                    reg_rdata <= mode_reg_q;
                    reg_rdata[4] <= 1'b0;
                    reg_rdata[scp_pkg::F_SLOW_RDY] <= slow_rdy;
                    reg_rdata[scp_pkg::F_FAST_RDY] <= fast_rdy;
                end
                scp_pkg::ADDR_MODE_EXT:
                    reg_rdata <= {sys_idle_q, 7'h00};
                scp_pkg::ADDR_STATUS:
                    reg_rdata <= {5'h00, mode_q};
                default:
                    reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

    // ready-gated switch
    // Selection is adopted on a sys tick boundary, or at once while halted, once the target is ready
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            use_slow_q <= 1'b0;
            cur_div_q <= scp_pkg::DIV_SLOW_A;
            cur_hl_q <= 1'b1;
        end
        // A halted CPU has no clock edge to clip, so the switch need not wait there
        else if ((want_slow ? slow_rdy : fast_rdy) && (sys_tick || halted_q))
        begin
            use_slow_q <= want_slow;
            cur_div_q <= mode_reg_q[scp_pkg::F_DIV_HI:scp_pkg::F_DIV_LO];
            cur_hl_q <= mode_reg_q[scp_pkg::F_HL_SEL];
        end
    end

    // Fast prescaler counts fast ticks
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            pre_q <= 6'h00;
        else if (fast_tick)
            pre_q <= pre_q + 6'h01;
    end

    always_comb
    begin
        // Prescaler bits that must all be set for one divided tick
        pre_need = scp_pkg::PRE_ONES >> (cur_div_q - scp_pkg::DIV_BASE);
        if (use_slow_q)
            sys_tick = slow_tick;
        else if (cur_hl_q)
            sys_tick = fast_tick;
        else
            sys_tick = fast_tick && ((pre_q & pre_need) == pre_need);
    end

    always_comb
    begin
        mode_d = mode_q;
        case (mode_q)
            scp_pkg::MODE_NORMAL,
            scp_pkg::MODE_SLOW:
            begin
                if (halt_req)
                begin
                    if (!mode_reg_q[scp_pkg::F_IDLE_EN])
                        mode_d = watchdog_on ? scp_pkg::MODE_SLEEP_WDT : scp_pkg::MODE_DEEP_SLEEP;
                    else
                        mode_d = sys_idle_q ? scp_pkg::MODE_IDLE_ON : scp_pkg::MODE_IDLE_OFF;
                end
                else
                    mode_d = use_slow_q ? scp_pkg::MODE_SLOW : scp_pkg::MODE_NORMAL;
            end
            scp_pkg::MODE_DEEP_SLEEP,
            scp_pkg::MODE_SLEEP_WDT,
            scp_pkg::MODE_IDLE_OFF,
            scp_pkg::MODE_IDLE_ON:
            begin
                if (wake_req)
                    mode_d = use_slow_q ? scp_pkg::MODE_SLOW : scp_pkg::MODE_NORMAL;
            end
            default:
                mode_d = scp_pkg::MODE_NORMAL;
        endcase
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            mode_q <= scp_pkg::MODE_NORMAL;
            halted_q <= 1'b0;
        end
        else
        begin
            mode_q <= mode_d;
            halted_q <= (mode_d != scp_pkg::MODE_NORMAL) && (mode_d != scp_pkg::MODE_SLOW);
        end
    end

    // Clock enables, registered
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            clk_out <= '0;
        else
        begin
            clk_out.cpu_en <= sys_tick && !halted_q;
            clk_out.sys_en <= sys_tick && (!halted_q || mode_q == scp_pkg::MODE_IDLE_ON);
            clk_out.slow_en <= slow_tick;
            clk_out.timebase_en <= slow_tick && mode_q != scp_pkg::MODE_SLEEP_WDT;
            clk_out.fast_on <= fast_run && fast_rdy;
        end
    end

    AST_CPU_HALT: assert property (@(posedge clock) disable iff (!rst_sync_n)
        halted_q |=> !clk_out.cpu_en) else $error("cpu clock while halted");

    AST_DEEP_SLOW_OFF: assert property (@(posedge clock) disable iff (!rst_sync_n)
        (mode_q == scp_pkg::MODE_DEEP_SLEEP) [*2] |=> !clk_out.slow_en)
        else $error("slow clock in deep sleep");

    AST_SLEEP_TB_OFF: assert property (@(posedge clock) disable iff (!rst_sync_n)
        mode_q == scp_pkg::MODE_SLEEP_WDT |=> !clk_out.timebase_en)
        else $error("time-base in sleep");

    AST_IDLE_OFF_SYS: assert property (@(posedge clock) disable iff (!rst_sync_n)
        mode_q == scp_pkg::MODE_IDLE_OFF && halted_q |=> !clk_out.sys_en)
        else $error("system clock in idle off");

    AST_SLOW_FAST_OFF: assert property (@(posedge clock) disable iff (!rst_sync_n)
        use_slow_q && want_slow |=> !clk_out.fast_on)
        else $error("fast clock on in slow");

    AST_HALT_ENTRY: assert property (@(posedge clock) disable iff (!rst_sync_n)
        (mode_q == scp_pkg::MODE_NORMAL && halt_req && mode_reg_q[scp_pkg::F_IDLE_EN]
        && sys_idle_q) |=> mode_q == scp_pkg::MODE_IDLE_ON)
        else $error("idle on entry");

    AST_IDLE_ON_SYS: assert property (@(posedge clock) disable iff (!rst_sync_n)
        mode_q == scp_pkg::MODE_IDLE_ON && sys_tick |=> clk_out.sys_en)
        else $error("system clock missing in idle on");

    AST_SWITCH_READY: assert property (@(posedge clock) disable iff (!rst_sync_n)
        $rose(use_slow_q) |-> $past(slow_rdy)) else $error("switch before ready");

    AST_HL_FULL: assert property (@(posedge clock) disable iff (!rst_sync_n)
        !use_slow_q && cur_hl_q && fast_tick && !halted_q |=> clk_out.cpu_en)
        else $error("undivided fast missing");
endmodule // scp_ctrl
`default_nettype wire

// file: test/scp_ctrl_tb.sv
// Self-checking testbench for the clock selection and power mode controller
`default_nettype none
module scp_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic halt_req = 1'b0;
    logic wake_req = 1'b0;
    logic watchdog_on = 1'b0;
    scp_pkg::scp_clk_t clk_out;
    scp_pkg::scp_mode_t mode_q;
    int err_total = 0;
    int total_checks = 0;
    localparam int SD = scp_pkg::SLOW_DIV;

    scp_ctrl i_scp_ctrl (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_req(halt_req),
        .wake_req(wake_req), .watchdog_on(watchdog_on), .clk_out(clk_out), .mode_q(mode_q)
    );

    always #4 clock = ~clock;

    task automatic bad(input logic [31:0] got, input logic [31:0] exp);
        err_total++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
            bad(got, exp);
    endtask
    task automatic chk_mode(input scp_pkg::scp_mode_t got, input scp_pkg::scp_mode_t exp);
        total_checks++;
        if (got !== exp)
            bad(got, exp);
    endtask
    task automatic chk_cnt(input int got, input int exp);
        total_checks++;
        if (got != exp)
            bad(got, exp);
    endtask

    task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic bus_rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // One-cycle pulse on the wake line if wake is set, else on the halt line
    task automatic pulse(input logic wake);
        @(posedge clock);
        if (wake)
            wake_req <= 1'b1;
        else
            halt_req <= 1'b1;
        @(posedge clock);
        wake_req <= 1'b0;
        halt_req <= 1'b0;
        #1;
    endtask
    // First gap after a switch may be short, so the second one is used
    task automatic sys_gap(output int g);
        int n;
        repeat (2)
        begin
            n = 0;
            while (clk_out.sys_en !== 1'b1 && n < 5000)
            begin
                @(posedge clock);
                #1 n++;
            end
            g = 0;
            do
            begin
                @(posedge clock);
                #1 g++;
            end while (clk_out.sys_en !== 1'b1 && g < 5000);
        end
    endtask
    task automatic count_win(input int n, output int s, output int l, output int t,
                             output int c);
        s = 0;
        l = 0;
        t = 0;
        c = 0;
        repeat (n)
        begin
            @(posedge clock);
            #1;
            s += (clk_out.sys_en === 1'b1);
            l += (clk_out.slow_en === 1'b1);
            t += (clk_out.timebase_en === 1'b1);
            c += (clk_out.cpu_en === 1'b1);
        end
    endtask

    task automatic t_reset();
        logic [7:0] d;
        int n;
        n = 0;
        do
        begin
            bus_rd(scp_pkg::ADDR_MODE, d);
            n++;
        end while (d[3:2] !== 2'b11 && n < 10000);
        chk8(d, scp_pkg::MODE_RESET | 8'h0C);
        bus_rd(scp_pkg::ADDR_MODE_EXT, d);
        chk8(d, scp_pkg::MODE_EXT_RESET);
        bus_rd(2'h3, d);
        chk8(d, 8'h00);
        chk_mode(mode_q, scp_pkg::MODE_NORMAL);
        chk8(clk_out.fast_on, 8'h01);
    endtask

    task automatic t_regs();
        logic [7:0] d;
        bus_wr(scp_pkg::ADDR_MODE, 8'hFF);
        bus_rd(scp_pkg::ADDR_MODE, d);
        chk8(d, 8'hEF);
        bus_wr(2'h3, 8'hFF);
        bus_rd(2'h3, d);
        chk8(d, 8'h00);
        bus_wr(scp_pkg::ADDR_MODE_EXT, 8'hFF);
        bus_rd(scp_pkg::ADDR_MODE_EXT, d);
        chk8(d, 8'h80);
        bus_wr(scp_pkg::ADDR_MODE_EXT, 8'h00);
        bus_wr(scp_pkg::ADDR_MODE, 8'h03);
    endtask

    task automatic t_div();
        int g;
        for (int code = 2; code < 8; code++)
        begin
            bus_wr(scp_pkg::ADDR_MODE, {code[2:0], 5'h02});
            sys_gap(g);
            chk_cnt(g, scp_pkg::FAST_DIV << (8 - code));
            chk_mode(mode_q, scp_pkg::MODE_NORMAL);
        end
        bus_wr(scp_pkg::ADDR_MODE, 8'hE3);
        sys_gap(g);
        chk_cnt(g, scp_pkg::FAST_DIV);
        bus_wr(scp_pkg::ADDR_MODE, 8'h03);
    endtask

    task automatic t_slow();
        logic [7:0] d;
        int g, s, l, t, c, n;
        bus_wr(scp_pkg::ADDR_MODE, 8'h02);
        n = 0;
        while (mode_q !== scp_pkg::MODE_SLOW && n < 20000)
        begin
            @(posedge clock);
            #1 n++;
        end
        chk_mode(mode_q, scp_pkg::MODE_SLOW);
        sys_gap(g);
        chk_cnt(g, SD);
        chk8(clk_out.fast_on, 8'h00);
        count_win(SD + 20, s, l, t, c);
        chk_cnt(t > 0, 1);
        chk_cnt(l > 0, 1);
        chk_cnt(c > 0, 1);
        bus_rd(scp_pkg::ADDR_STATUS, d);
        chk8(d, 8'h01);
        bus_wr(scp_pkg::ADDR_MODE, 8'h22);
        sys_gap(g);
        chk_cnt(g, SD);
        chk_mode(mode_q, scp_pkg::MODE_SLOW);
        bus_wr(scp_pkg::ADDR_MODE, 8'h03);
        n = 0;
        while ((mode_q !== scp_pkg::MODE_NORMAL || clk_out.fast_on !== 1'b1) && n < 10000)
        begin
            @(posedge clock);
            #1 n++;
        end
        chk_mode(mode_q, scp_pkg::MODE_NORMAL);
        chk8(clk_out.fast_on, 8'h01);
    endtask

    // Halt table: idle enable, sysclk in idle, watchdog, then what must keep running
    task automatic t_halt();
        logic [2:0] cfg [4] = '{3'b000, 3'b001, 3'b100, 3'b110};
        logic [2:0] run [4] = '{3'b000, 3'b010, 3'b011, 3'b111};
        scp_pkg::scp_mode_t em [4] = '{scp_pkg::MODE_DEEP_SLEEP, scp_pkg::MODE_SLEEP_WDT,
                                       scp_pkg::MODE_IDLE_OFF, scp_pkg::MODE_IDLE_ON};
        int s, l, t, c, n;
        for (int i = 0; i < 4; i++)
        begin
            bus_wr(scp_pkg::ADDR_MODE_EXT, {cfg[i][1], 7'h00});
            bus_wr(scp_pkg::ADDR_MODE, {6'h00, cfg[i][2], 1'b1});
            watchdog_on <= cfg[i][0];
            pulse(1'b0);
            chk_mode(mode_q, em[i]);
            count_win(2 * SD, s, l, t, c);
            chk_cnt(c, 0);
            chk_cnt(s > 0, run[i][2]);
            chk_cnt(l > 0, run[i][1]);
            chk_cnt(t > 0, run[i][0]);
            chk8(clk_out.fast_on, {7'h00, run[i][2]});
            pulse(1'b1);
            chk_mode(mode_q, scp_pkg::MODE_NORMAL);
            n = 0;
            while (clk_out.fast_on !== 1'b1 && n < 5000)
            begin
                @(posedge clock);
                #1 n++;
            end
        end
        watchdog_on <= 1'b0;
    endtask

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_div();
        t_slow();
        t_halt();
        wrap_up();
    end

    // Expected run is near 75000 cycles
    initial
    begin
        repeat (95000) @(posedge clock);
        err_total++;
        wrap_up();
    end
endmodule // scp_ctrl_tb
`default_nettype wire
